// file: verilog/sfm_pkg.sv
// Constants, types and register map of the supply fault manager.
// Summary of operation
// - Measure pulse rate per rail, flag sustained excess.
// - Four rate limits: 30, 41, 56, 78 kHz.
// - Strap resistors set rail one and backlight limits.
// - Strap capacitors set rail two limit.
// - Tolerate excess rate for at least 10 ms.
// - Overvoltage on any feedback sense is a fault.
// - Large string asymmetry disables the shorter strings.
// - Open or shorted strings are disabled.
// - Grounded string stays disabled after backlight power-limit restart.
// - Overtemperature drops rails, holds backlight keepalive, restarts.
// - Thermal shutdown immediately requests primary latch-off.
// - Every rail or thermal fault resolves by restart or latch-off.
// - Auto-restart stops all switching-cycle requests.
// - Latch-off sends a latch-off request to primary.
// - Undervolt for over 32 cycles means overload.
package sfm_pkg;

	localparam int CLK_HZ          = 50_000_000;
	localparam int WIN_US          = 1000;
	localparam int WIN_CYC_DEF     = CLK_HZ / 1_000_000 * WIN_US;
	localparam int QUAL_MS         = 10;
	localparam int QUAL_WIN        = (QUAL_MS * 1000 + WIN_US - 1) / WIN_US;
	localparam int OVL_CYCLES      = 32;
	localparam int RESTART_US      = 1000;
	localparam int RESTART_CYC_DEF = CLK_HZ / 1_000_000 * RESTART_US;
	localparam int SETTLE_CYC      = 4;
	localparam int PCNT_MAX        = 255;

	// Rate limit levels in kHz, indexed by the two-bit strap code.
	localparam int LIM_KHZ [4] = '{30, 41, 56, 78};

	// Resistor codes reported by the strap decoder.
	typedef enum logic [1:0] {
		RES_5K1 = 2'b00,
		RES_10K = 2'b01,
		RES_22K = 2'b10,
		RES_39K = 2'b11
	} sfm_res_t;

	typedef enum logic [2:0] {
		ST_INIT  = 3'b000,
		ST_RUN   = 3'b001,
		ST_HOLD  = 3'b010,
		ST_THERM = 3'b011,
		ST_LATCH = 3'b100
	} sfm_state_t;

	// Register byte offsets.
	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_MASK   = 12'h004;
	localparam logic [11:0] REG_CTRL   = 12'h008;
	localparam logic [11:0] REG_STATE  = 12'h00C;

	// Status and mask bit positions.
	localparam int SB_PLIM = 0;
	localparam int SB_OVL  = 3;
	localparam int SB_OV   = 6;
	localparam int SB_TEMP = 9;
	localparam int SB_TSD  = 10;
	localparam int SB_STR  = 11;
	localparam int SB_W    = 12;

	// Synchronised monitor inputs, grouped as they arrive from the pins.
	typedef struct packed {
		logic [2:0] pulse;
		logic [2:0] undervolt;
		logic [2:0] ov;
		logic [3:0] asym;
		logic [3:0] open;
		logic [3:0] short;
		logic [3:0] gnd;
		logic       hot;
		logic       cool;
		logic       tsd;
		logic [1:0] res_a;
		logic [1:0] res_b;
		logic       cap_a;
		logic       cap_b;
		logic       latch_cfg;
	} sfm_mon_t;

endpackage

// file: verilog/sfm_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module sfm_sync import sfm_pkg::*; #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] o;
	} sfm_sync_st_t;

	sfm_sync_st_t q, d;

	always_comb begin
		d    = q;
		d.s1 = din;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.o[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dout = q.o;

endmodule // sfm_sync

// file: verilog/sfm_rate_mon.sv
// Per-rail pulse rate limiter and overload counter.
`timescale 1ns/1ps
module sfm_rate_mon import sfm_pkg::*; #(
	parameter int WIN_CYC = WIN_CYC_DEF
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Monitor inputs
	input  wire logic       clr,
	input  wire logic       pulse,
	input  wire logic       undervolt,
	input  wire logic [7:0] limit,
	// Fault pulses
	output logic            plim_fault,
	output logic            ovl_fault
);

	localparam int CW = $clog2(WIN_CYC + 1);
	localparam int QW = $clog2(QUAL_WIN + 1);

	typedef struct packed {
		logic [CW-1:0] win;
		logic [7:0]    pcnt;
		logic [QW-1:0] over;
		logic [5:0]    uv;
		logic          plim;
		logic          ovl;
	} sfm_rate_st_t;

	sfm_rate_st_t q, d;

	always_comb begin
		d      = q;
		d.plim = 1'b0;
		d.ovl  = 1'b0;
		if (clr) begin
			d = '0;
		end else begin
			if (pulse && q.pcnt != 8'(PCNT_MAX)) begin
				d.pcnt = q.pcnt + 8'd1;
			end
			if (!undervolt) begin
				d.uv = '0;
			end else if (pulse) begin
				if (q.uv == 6'(OVL_CYCLES)) begin
					d.ovl = 1'b1;
				end else begin
					d.uv = q.uv + 6'd1;
				end
			end
			if (q.win == CW'(WIN_CYC - 1)) begin
				d.win  = '0;
				d.pcnt = 8'(pulse);
				if (q.pcnt > limit) begin
					if (q.over == QW'(QUAL_WIN)) begin
						d.plim = 1'b1;
					end else begin
						d.over = q.over + QW'(1);
					end
				end else begin
					d.over = '0;
				end
			end else begin
				d.win = q.win + CW'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign plim_fault = q.plim;
	assign ovl_fault  = q.ovl;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_plim_qual;
		q.plim |-> $past(q.over) == QW'(QUAL_WIN);
	endproperty
	a_plim_qual: assert property (p_plim_qual) else $error("Rate fault without full qualify count.");

	property p_ovl_count;
		q.ovl |-> $past(q.uv) == 6'(OVL_CYCLES) && $past(undervolt);
	endproperty
	a_ovl_count: assert property (p_ovl_count) else $error("Overload flagged before 33 cycles.");

endmodule // sfm_rate_mon

// file: verilog/sfm_top.sv
// Supply fault manager top level with APB register slave.
`timescale 1ns/1ps
module sfm_top import sfm_pkg::*; #(
	parameter int WIN_CYC     = WIN_CYC_DEF,
	parameter int RESTART_CYC = RESTART_CYC_DEF
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Rail monitors
	input  wire logic [2:0]  rail_pulse,
	input  wire logic [2:0]  rail_undervolt,
	input  wire logic [2:0]  feedback_sense_ov,
	// String monitors
	input  wire logic [3:0]  string_asym_short,
	input  wire logic [3:0]  string_open,
	input  wire logic [3:0]  string_short,
	input  wire logic [3:0]  string_sink_grounded,
	// Thermal monitors
	input  wire logic        thermal_limit_hot,
	input  wire logic        thermal_hysteresis_clear,
	input  wire logic        thermal_shutdown_hot,
	// Straps and configuration
	input  wire logic [1:0]  power_strap_a_res,
	input  wire logic [1:0]  power_strap_b_res,
	input  wire logic        power_strap_a_cap,
	input  wire logic        power_strap_b_cap,
	input  wire logic        latch_mode_cfg,
	// Supply control
	output logic             cycle_req_en,
	output logic             latchoff_req,
	output logic             fixed_rail_one_en,
	output logic             fixed_rail_two_en,
	output logic             backlight_keepalive,
	output logic [3:0]       string_en,
	output logic             irq
);

	localparam int HW = $clog2(RESTART_CYC + 1);

	typedef struct packed {
		sfm_state_t      state;
		logic            latch_mode;
		logic [1:0]      lim0;
		logic [1:0]      lim1;
		logic [1:0]      lim2;
		logic [3:0]      str_dis;
		logic [3:0]      sw_dis;
		logic [SB_W-1:0] status;
		logic [SB_W-1:0] mask;
		logic [HW-1:0]   cnt;
		logic            cyc_req;
		logic            latchoff;
		logic            rail_one;
		logic            rail_two;
		logic            keepalive;
		logic [3:0]      str_en;
		logic            irq;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
	} sfm_top_st_t;

	sfm_top_st_t     q, d;
	sfm_mon_t        m;
	logic [2:0]      plim_ev;
	logic [2:0]      ovl_ev;
	logic [7:0]      lim_cnt [3];
	logic            mon_clr;
	logic [3:0]      strf;
	logic [1:0]      cap_code;
	logic            fault_any;

	sfm_sync #(.W($bits(sfm_mon_t))) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({rail_pulse, rail_undervolt, feedback_sense_ov, string_asym_short, string_open,
		           string_short, string_sink_grounded, thermal_limit_hot, thermal_hysteresis_clear,
		           thermal_shutdown_hot, power_strap_a_res, power_strap_b_res, power_strap_a_cap,
		           power_strap_b_cap, latch_mode_cfg}),
		.dout    (m)
	);

	assign lim_cnt[0] = 8'(LIM_KHZ[q.lim0] * WIN_US / 1000);
	assign lim_cnt[1] = 8'(LIM_KHZ[q.lim1] * WIN_US / 1000);
	assign lim_cnt[2] = 8'(LIM_KHZ[q.lim2] * WIN_US / 1000);
	assign mon_clr    = q.state != ST_RUN;

	// Pulses are edge-detected ahead of each monitor so a wide pulse counts once.
	logic [2:0] pulse_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_q <= '0;
		end else begin
			pulse_q <= m.pulse;
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_rail
		sfm_rate_mon #(.WIN_CYC(WIN_CYC)) u_mon (
			.pclk       (pclk),
			.presetn    (presetn),
			.clr        (mon_clr),
			.pulse      (m.pulse[g] & ~pulse_q[g]),
			.undervolt  (m.undervolt[g]),
			.limit      (lim_cnt[g]),
			.plim_fault (plim_ev[g]),
			.ovl_fault  (ovl_ev[g])
		);
	end

	assign strf      = m.asym | m.open | m.short;
	assign cap_code  = {m.cap_b, m.cap_a};
	assign fault_any = |plim_ev || |ovl_ev || |m.ov;

	always_comb begin
		logic [SB_W-1:0] set;
		logic [SB_W-1:0] w1c;
		logic            setup;
		logic            acc;
		logic            hit;
		logic [31:0]     rd;
		set   = '0;
		w1c   = '0;
		rd    = '0;
		d     = q;
		setup = psel & ~penable;
		acc   = psel & penable & q.pready;
		hit   = paddr == REG_STATUS || paddr == REG_MASK || paddr == REG_CTRL || paddr == REG_STATE;
		case (paddr)
			REG_STATUS: rd = 32'(q.status);
			REG_MASK:   rd = 32'(q.mask);
			REG_CTRL:   rd = 32'(q.sw_dis);
			REG_STATE:  rd = 32'({q.str_dis, q.lim2, q.lim1, q.lim0, q.latch_mode, q.state});
			default:    rd = '0;
		endcase
		d.pready  = setup;
		d.pslverr = setup & ~hit;
		d.prdata  = (setup & ~pwrite) ? rd : '0;
		if (acc && pwrite) begin
			case (paddr)
				REG_STATUS: w1c = pwdata[SB_W-1:0];
				REG_MASK:   d.mask = pwdata[SB_W-1:0];
				REG_CTRL:   d.sw_dis = pwdata[3:0];
				default:    ;
			endcase
		end
		case (q.state)
			ST_INIT: begin
				d.cyc_req = 1'b0;
				// The synchroniser shows a strap only after four edges, so sample one edge later.
				if (q.cnt == HW'(SETTLE_CYC)) begin
					d.lim0       = m.res_a;
					d.lim2       = m.res_b;
					d.lim1       = cap_code;
					d.latch_mode = m.latch_cfg;
					d.state      = ST_RUN;
					d.cyc_req    = 1'b1;
					d.cnt        = '0;
				end else begin
					d.cnt = q.cnt + HW'(1);
				end
			end
			ST_RUN: begin
				d.str_dis         = q.str_dis | strf;
				set[SB_STR]       = |(strf & ~q.str_dis);
				set[SB_PLIM+:3]   = plim_ev;
				set[SB_OVL+:3]    = ovl_ev;
				set[SB_OV+:3]     = m.ov;
				if (fault_any) begin
					if (plim_ev[2]) begin
						d.str_dis = d.str_dis | m.gnd;
					end
					d.state    = q.latch_mode ? ST_LATCH : ST_HOLD;
					d.latchoff = q.latch_mode;
					d.cyc_req  = 1'b0;
					d.cnt      = '0;
				end else if (m.hot) begin
					d.state       = ST_THERM;
					set[SB_TEMP]  = 1'b1;
				end
			end
			ST_HOLD: begin
				d.cyc_req = 1'b0;
				if (q.cnt == HW'(RESTART_CYC - 1)) begin
					d.state   = ST_RUN;
					d.cyc_req = 1'b1;
					d.cnt     = '0;
				end else begin
					d.cnt = q.cnt + HW'(1);
				end
			end
			ST_THERM: begin
				if (m.cool) begin
					d.state   = ST_HOLD;
					d.cyc_req = 1'b0;
					d.cnt     = '0;
				end
			end
			ST_LATCH: begin
				d.latchoff = 1'b1;
				d.cyc_req  = 1'b0;
			end
			default: begin
				d.state = ST_INIT;
			end
		endcase
		if (m.tsd) begin
			d.state     = ST_LATCH;
			d.latchoff  = 1'b1;
			d.cyc_req   = 1'b0;
			set[SB_TSD] = 1'b1;
		end
		d.rail_one  = d.state == ST_RUN;
		d.rail_two  = d.state == ST_RUN;
		d.keepalive = d.state == ST_THERM;
		d.str_en    = (d.state == ST_RUN) ? ~(d.str_dis | d.sw_dis) : 4'h0;
		// A new event wins over a clear written in the same cycle.
		d.status    = (q.status & ~w1c) | set;
		d.irq       = |(d.status & d.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign prdata              = q.prdata;
	assign pready              = q.pready;
	assign pslverr             = q.pslverr;
	assign cycle_req_en        = q.cyc_req;
	assign latchoff_req        = q.latchoff;
	assign fixed_rail_one_en   = q.rail_one;
	assign fixed_rail_two_en   = q.rail_two;
	assign backlight_keepalive = q.keepalive;
	assign string_en           = q.str_en;
	assign irq                 = q.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_tsd;
		m.tsd |=> q.latchoff && !q.cyc_req && q.state == ST_LATCH;
	endproperty
	a_tsd: assert property (p_tsd) else $error("Shutdown did not latch off.");

	property p_latch;
		q.state == ST_LATCH |=> q.state == ST_LATCH && q.latchoff && !q.rail_one;
	endproperty
	a_latch: assert property (p_latch) else $error("Latch-off state left or request dropped.");

	property p_hold;
		q.state == ST_HOLD |-> !q.cyc_req && !q.latchoff && q.str_en == 4'h0;
	endproperty
	a_hold: assert property (p_hold) else $error("Cycle requests during restart hold.");

	property p_resp;
		(q.state == ST_RUN && fault_any && !m.tsd) |=> q.state != ST_RUN && (q.state == ST_LATCH) == q.latch_mode;
	endproperty
	a_resp: assert property (p_resp) else $error("Fault response does not match mode.");

	property p_therm;
		(q.state == ST_RUN && m.hot && !fault_any && !m.tsd) |=> q.keepalive && q.cyc_req && !q.rail_one
			&& !q.rail_two && q.str_en == 4'h0;
	endproperty
	a_therm: assert property (p_therm) else $error("Overtemperature outputs wrong.");

	property p_str;
		(q.state == ST_RUN && |strf) |=> (q.str_en & $past(strf)) == 4'h0;
	endproperty
	a_str: assert property (p_str) else $error("Faulty string still enabled.");

	property p_gnd;
		(q.state == ST_RUN && plim_ev[2] && !m.tsd) |=> (q.str_dis & $past(m.gnd)) == $past(m.gnd);
	endproperty
	a_gnd: assert property (p_gnd) else $error("Grounded string not kept disabled.");

	property p_strap;
		($past(q.state) == ST_INIT && q.state == ST_RUN) |-> q.lim1 == $past(cap_code);
	endproperty
	a_strap: assert property (p_strap) else $error("Rail two limit not taken from caps.");

	property p_strap_res;
		($past(q.state) == ST_INIT && q.state == ST_RUN) |-> q.lim0 == $past(m.res_a) && q.lim2 == $past(m.res_b);
	endproperty
	a_strap_res: assert property (p_strap_res) else $error("Resistor strap limits not taken.");

	property p_ov_flag;
		(q.state == ST_RUN && |m.ov) |=> (q.status[SB_OV+:3] & $past(m.ov)) == $past(m.ov);
	endproperty
	a_ov_flag: assert property (p_ov_flag) else $error("Overvoltage not flagged in status.");

	property p_plim_flag;
		(q.state == ST_RUN && |plim_ev) |=> (q.status[SB_PLIM+:3] & $past(plim_ev)) == $past(plim_ev);
	endproperty
	a_plim_flag: assert property (p_plim_flag) else $error("Rate fault not flagged in status.");

	property p_cool;
		(q.state == ST_THERM && m.cool && !m.tsd) |=> q.state == ST_HOLD && !q.cyc_req;
	endproperty
	a_cool: assert property (p_cool) else $error("Thermal hold did not restart after cooling.");

	property p_restart;
		(q.state == ST_HOLD && q.cnt == HW'(RESTART_CYC - 1) && !m.tsd) |=> q.state == ST_RUN && q.cyc_req;
	endproperty
	a_restart: assert property (p_restart) else $error("Restart hold did not resume cycle requests.");

	property p_mode_kept;
		q.state != ST_INIT |=> $stable(q.latch_mode);
	endproperty
	a_mode_kept: assert property (p_mode_kept) else $error("Fault mode changed after reset sampling.");

	c_hold:  cover property (q.state == ST_RUN ##1 q.state == ST_HOLD);
	c_latch: cover property (q.state == ST_RUN ##1 q.state == ST_LATCH);
	c_therm: cover property (q.state == ST_THERM ##1 q.state == ST_HOLD);

endmodule // sfm_top

// file: verification/sfm_primary_model.sv
// Behavioural primary-side switcher that feeds switching pulses to the rails.
`timescale 1ns/1ps
module sfm_primary_model #(
	parameter int TMO = 10
) (
	// Clock and mains
	input  wire logic       pclk,
	input  wire logic       mains_ok,
	// Requests from the secondary
	input  wire logic       cycle_req_en,
	input  wire logic       latchoff_req,
	input  wire logic [7:0] period,
	// Pulses and status
	output logic      [2:0] rail_pulse,
	output logic            latched,
	output int              restarts
);
	int ph;
	int idle;
	always_ff @(posedge pclk or negedge mains_ok) begin
		if (!mains_ok) begin
			ph <= 0;
			idle <= 0;
			latched <= 1'b0;
			restarts <= 0;
		end else begin
			if (latchoff_req)
				latched <= 1'b1;
			if (cycle_req_en)
				idle <= 0;
			else if (idle == TMO) begin
				idle <= 0;
				restarts <= restarts + 1;
			end else
				idle <= idle + 1;
			ph <= (ph + 1 >= period) ? 0 : ph + 1;
		end
	end
	// Pulses flow only while cycles are requested, so a collapse is visible to the monitor.
	assign rail_pulse = (cycle_req_en && !latched && ph < period / 2) ? 3'b111 : 3'b000;
endmodule // sfm_primary_model

// file: verification/supply_fault_manager_test.sv
// Self-checking bench of the supply fault manager.
`timescale 1ns/1ps
module supply_fault_manager_test import sfm_pkg::*;;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic        pready, pslverr;
	logic [2:0]  rail_pulse, uv = 0, ov = 0;
	logic [3:0]  asym = 0, opn = 0, sht = 0, gnd = 0, string_en;
	logic        hot = 0, clr = 0, tsd = 0, lcfg = 0;
	logic [1:0]  res_a = 0, res_b = 0;
	logic        cap_a = 0, cap_b = 0, cycle_req_en, latchoff_req, r1_en, r2_en, keep, irq, latched;
	logic [7:0]  period = 20;
	logic [64:0] q[$];
	int          restarts, error_cnt = 0, checks = 0, cyc = 0, i, k;
	logic [31:0] seed;
	logic [5:0]  s;
	sfm_top #(.WIN_CYC(300), .RESTART_CYC(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rail_pulse(rail_pulse), .rail_undervolt(uv),
		.feedback_sense_ov(ov), .string_asym_short(asym), .string_open(opn), .string_short(sht),
		.string_sink_grounded(gnd), .thermal_limit_hot(hot), .thermal_hysteresis_clear(clr),
		.thermal_shutdown_hot(tsd), .power_strap_a_res(res_a), .power_strap_b_res(res_b),
		.power_strap_a_cap(cap_a), .power_strap_b_cap(cap_b), .latch_mode_cfg(lcfg),
		.cycle_req_en(cycle_req_en), .latchoff_req(latchoff_req), .fixed_rail_one_en(r1_en),
		.fixed_rail_two_en(r2_en), .backlight_keepalive(keep), .string_en(string_en), .irq(irq));
	sfm_primary_model #(.TMO(10)) prim (.pclk(pclk), .mains_ok(presetn), .cycle_req_en(cycle_req_en),
		.latchoff_req(latchoff_req), .period(period), .rail_pulse(rail_pulse), .latched(latched),
		.restarts(restarts));
	initial forever #10 pclk = ~pclk;
	task results;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task cmp_pin(input string n, input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask
	task cmp_apb(input logic [64:0] n);
		checks++;
		if ((prdata & n[63:32]) !== (n[31:0] & n[63:32]) || pslverr !== n[64]) begin
			error_cnt++;
			$display("mismatch apb expected %h seen %h", n, {pslverr, prdata});
		end
	endtask
	// Notes hold {pslverr, mask, data}; the watcher compares each transfer at its completing edge.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			if (q.size() == 0) begin
				error_cnt++;
				$display("mismatch apb expected none seen %h", prdata);
			end else
				cmp_apb(q.pop_front());
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
		q.push_back({e, m, d});
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 0;
		penable <= 0;
	endtask
	task rst(input logic l, input logic [5:0] st);
		presetn <= 0;
		lcfg <= l;
		{res_a, res_b, cap_a, cap_b} <= st;
		{uv, ov, asym, opn, sht, gnd, hot, clr, tsd} <= 0;
		period <= 20;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		repeat (12) @(posedge pclk);
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			results;
		end
	end
	initial begin
		seed = 32'h21b4;
		for (i = 0; i < 4; i++) begin
			s = {i[1:0], 2'(3 - i), i[1:0]};
			rst(0, s);
			apb(0, REG_STATE, {22'h0, s[3:2], s[0], s[1], s[5:4], 4'h1}, 32'h0000_03FF, 0);
		end
		apb(0, 12'h100, 32'h0000_0000, 32'hFFFF_FFFF, 1);
		apb(1, REG_MASK, 32'h0000_0FFF, 32'h0000_0000, 0);
		k = {$random(seed)} % 3;
		ov[k] <= 1;
		repeat (7) @(posedge pclk);
		cmp_pin("cycle_req_en", cycle_req_en, 0);
		cmp_pin("irq", irq, 1);
		ov[k] <= 0;
		apb(0, REG_STATUS, 32'(1) << (SB_OV + k), 32'h0000_0FFF, 0);
		apb(1, REG_STATUS, 32'h0000_0FFF, 32'h0000_0000, 0);
		apb(0, REG_STATUS, 32'h0000_0000, 32'h0000_0FFF, 0);
		cmp_pin("irq", irq, 0);
		repeat (30) @(posedge pclk);
		cmp_pin("cycle_req_en", cycle_req_en, 1);
		cmp_pin("restarts", restarts > 0, 1);
		k = {$random(seed)} % 3;
		uv[k] <= 1;
		repeat (500) @(posedge pclk);
		apb(0, REG_STATUS, 32'h0000_0000, 32'(1) << (SB_OVL + k), 0);
		repeat (300) @(posedge pclk);
		apb(0, REG_STATUS, 32'(1) << (SB_OVL + k), 32'(1) << (SB_OVL + k), 0);
		uv[k] <= 0;
		repeat (40) @(posedge pclk);
		opn[0] <= 1;
		asym[2] <= 1;
		repeat (8) @(posedge pclk);
		cmp_pin("string_en", string_en, 4'b1010);
		sht[3] <= 1;
		repeat (8) @(posedge pclk);
		cmp_pin("string_en", string_en, 4'b0010);
		// Three-cycle-high pulses give 50 per window, well above the lowest limit of 30.
		rst(0, 6'h00);
		gnd[1] <= 1;
		period <= 6;
		repeat (2700) @(posedge pclk);
		apb(0, REG_STATUS, 32'h0000_0000, 32'h0000_0007, 0);
		repeat (1100) @(posedge pclk);
		apb(0, REG_STATUS, 32'h0000_0007, 32'h0000_0007, 0);
		gnd[1] <= 0;
		period <= 20;
		repeat (60) @(posedge pclk);
		cmp_pin("string_en", string_en, 4'b1101);
		rst(0, 6'h00);
		hot <= 1;
		repeat (8) @(posedge pclk);
		cmp_pin("rails", {r1_en, r2_en, keep}, 3'b001);
		cmp_pin("string_en", string_en, 4'b0000);
		hot <= 0;
		clr <= 1;
		repeat (40) @(posedge pclk);
		cmp_pin("rails", {r1_en, r2_en, keep}, 3'b110);
		tsd <= 1;
		repeat (8) @(posedge pclk);
		cmp_pin("latchoff_req", latchoff_req, 1);
		tsd <= 0;
		repeat (40) @(posedge pclk);
		cmp_pin("latched", {latched, cycle_req_en}, 2'b10);
		rst(1, 6'h00);
		ov[0] <= 1;
		repeat (8) @(posedge pclk);
		cmp_pin("latchoff_req", latchoff_req, 1);
		apb(0, REG_STATE, 32'h0000_000C, 32'h0000_000F, 0);
		results;
	end
endmodule // supply_fault_manager_test
